// *** hw/vcrc_cap_reg.sv ***
`timescale 1ns/1ps
module vcrc_cap_reg
  import vcrc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire vcrc_req_t cfg_req,
  output vcrc_rsp_t      cfg_rsp
);

  // Word-aligned decode of the configuration address.
  function automatic logic vcrc_hits(input logic [VCRC_ADDR_W-1:0] a);
    vcrc_hits = (a[VCRC_ADDR_W-1:2] == VCRC_CAP_OFFSET[VCRC_ADDR_W-1:2]);
  endfunction

  vcrc_cap_t cap_word;
  vcrc_rsp_t rsp_d;
  vcrc_rsp_t rsp_q;

  vcrc_cap_word u_word
  (
    .cap (cap_word)
  );

  // The word is built from constants rather than held in flops: a value that
  // never changes needs no storage, and no write path can ever disturb it.
  always_comb
  begin
    rsp_d       = '0;
    rsp_d.ack   = cfg_req.valid;
    rsp_d.hit   = cfg_req.valid & vcrc_hits(cfg_req.addr); // R1
    if (cfg_req.valid && !cfg_req.write && vcrc_hits(cfg_req.addr))
    begin
      rsp_d.rdata = cap_word; // R1
    end
    // A write is acknowledged but has no effect on the returned value.
  end // R10

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_q <= '0;
    end
    else
    begin
      rsp_q <= rsp_d;
    end
  end

  assign cfg_rsp = rsp_q;

  // Helper state for the checks below.
  logic            wr_seen_q;
  vcrc_req_t       req_past_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_seen_q  <= 1'b0;
      req_past_q <= '0;
    end
    else
    begin
      req_past_q <= cfg_req;
      if (cfg_req.valid && cfg_req.write && vcrc_hits(cfg_req.addr))
      begin
        wr_seen_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_ack_follows;
    cfg_req.valid |=> cfg_rsp.ack;
  endproperty
  a_ack_follows : assert property (p_ack_follows) // R1
    else $error("request not acknowledged one cycle later");

  property p_no_spurious_ack;
    !cfg_req.valid |=> !cfg_rsp.ack && !cfg_rsp.hit;
  endproperty
  a_no_spurious_ack : assert property (p_no_spurious_ack) // R1
    else $error("acknowledge without a request");

  property p_read_value;
    cfg_req.valid && !cfg_req.write && vcrc_hits(cfg_req.addr)
      |=> cfg_rsp.hit && cfg_rsp.rdata == 32'h0000_0001;
  endproperty
  a_read_value : assert property (p_read_value) // R1
    else $error("read of the capability word returned a wrong value");

  property p_miss_quiet;
    cfg_req.valid && !vcrc_hits(cfg_req.addr)
      |=> !cfg_rsp.hit && cfg_rsp.rdata == 32'h0000_0000;
  endproperty
  a_miss_quiet : assert property (p_miss_quiet) // R1
    else $error("other address was claimed or returned data");

  property p_table_loc;
    cfg_rsp.ack && cfg_rsp.hit |-> cfg_rsp.rdata[31:24] == 8'h00;
  endproperty
  a_table_loc : assert property (p_table_loc) // R2
    else $error("table location field is not zero");

  property p_rsvd23;
    cfg_rsp.ack && cfg_rsp.hit |-> !cfg_rsp.rdata[23];
  endproperty
  a_rsvd23 : assert property (p_rsvd23) // R3
    else $error("reserved bit 23 is set");

  property p_slots;
    cfg_rsp.ack && cfg_rsp.hit |-> cfg_rsp.rdata[22:16] == 7'h00;
  endproperty
  a_slots : assert property (p_slots) // R4
    else $error("slot count field is not zero");

  property p_snoop;
    cfg_rsp.ack && cfg_rsp.hit |-> !cfg_rsp.rdata[15];
  endproperty
  a_snoop : assert property (p_snoop) // R5
    else $error("snoop rejection bit is set");

  property p_switching;
    cfg_rsp.ack && cfg_rsp.hit |-> !cfg_rsp.rdata[14];
  endproperty
  a_switching : assert property (p_switching) // R6
    else $error("switching-only bit is set");

  property p_rsvd13;
    cfg_rsp.ack && cfg_rsp.hit |-> cfg_rsp.rdata[13:8] == 6'h00;
  endproperty
  a_rsvd13 : assert property (p_rsvd13) // R7
    else $error("reserved bits 13 to 8 are not zero");

  property p_scheme_rsvd;
    cfg_rsp.ack && cfg_rsp.hit |-> cfg_rsp.rdata[7:6] == 2'h0;
  endproperty
  a_scheme_rsvd : assert property (p_scheme_rsvd) // R8
    else $error("reserved scheme bits are set");

  property p_scheme_value;
    cfg_rsp.ack && cfg_rsp.hit && !req_past_q.write
      |-> cfg_rsp.rdata[7:0] == 8'h01;
  endproperty
  a_scheme_value : assert property (p_scheme_value) // R9
    else $error("scheme field does not offer round-robin only");

  property p_write_no_data;
    cfg_req.valid && cfg_req.write |=> cfg_rsp.rdata == 32'h0000_0000;
  endproperty
  a_write_no_data : assert property (p_write_no_data) // R10
    else $error("write returned read data");

  sequence s_write_hit;
    cfg_req.valid && cfg_req.write && vcrc_hits(cfg_req.addr)
      && cfg_req.wdata != 32'h0000_0001;
  endsequence

  property p_write_ignored;
    s_write_hit ##1 (cfg_req.valid && !cfg_req.write
      && vcrc_hits(cfg_req.addr))
      |=> cfg_rsp.rdata == 32'h0000_0001;
  endproperty
  a_write_ignored : assert property (p_write_ignored) // R10
    else $error("value changed after a write");

  property p_reset_quiet;
    $fell(rst) |-> !cfg_rsp.ack && cfg_rsp.rdata == 32'h0000_0000;
  endproperty
  a_reset_quiet : assert property (@(posedge clk) p_reset_quiet) // R1
    else $error("response not idle after reset");

  c_read_hit : cover property (cfg_rsp.ack && cfg_rsp.hit
    && cfg_rsp.rdata == 32'h0000_0001);
  c_write_hit : cover property (cfg_req.valid && cfg_req.write
    && vcrc_hits(cfg_req.addr));
  c_miss : cover property (cfg_rsp.ack && !cfg_rsp.hit);
  c_write_then_read : cover property (wr_seen_q && cfg_rsp.ack
    && cfg_rsp.hit && cfg_rsp.rdata == 32'h0000_0001);

endmodule

// *** common/vcrc_pkg.sv ***
// Behaviour
// (R1) Config reads at extended offset 160h return the 32-bit word.
// (R2) Bits 31:24, the arbitration table location, read 00h: no table.
// (R3) Reserved bit 23 always reads zero.
// (R4) The slot count in bits 22:16 reads zero: no time-based weighting.
// (R5) The snoop rejection bit 15 reads zero, as it suits root ports only.
// (R6) The switching-only bit 14 reads zero: channel 0 carries any traffic.
// (R7) Reserved bits 13:8 always read zero.
// (R8) Bits 0-5: RR, WRR 32/64/128, timed WRR 128, WRR 256; 6-7 reserved.
// (R9) The scheme field reads 01h, fixed round-robin being the only scheme.
// (R10) Writes are ignored and the word reads 0000_0001h from reset onward.
package vcrc_pkg;

  localparam int          VCRC_ADDR_W      = 12;
  localparam int          VCRC_DATA_W      = 32;
  localparam logic [11:0] VCRC_CAP_OFFSET  = 12'h160;

  localparam logic [7:0]  VCRC_TBL_LOC     = 8'h00;
  localparam logic [6:0]  VCRC_SLOT_COUNT  = 7'h00;
  localparam logic        VCRC_SNOOP_REJ   = 1'h0;
  localparam logic        VCRC_SWITCH_ONLY = 1'h0;
  localparam logic [7:0]  VCRC_ARB_SUPPORT = 8'h01;
  localparam logic [7:0]  VCRC_ARB_RSVD    = 8'hC0;
  localparam logic [31:0] VCRC_CAP_RESET   = 32'h0000_0001;

  localparam int VCRC_TBL_LSB    = 24;
  localparam int VCRC_RSVD23_BIT = 23;
  localparam int VCRC_SLOT_LSB   = 16;
  localparam int VCRC_SNOOP_BIT  = 15;
  localparam int VCRC_SWITCH_BIT = 14;
  localparam int VCRC_RSVD13_LSB = 8;

  localparam int VCRC_ARB_FIXED_RR = 0;
  localparam int VCRC_ARB_WRR32    = 1;
  localparam int VCRC_ARB_WRR64    = 2;
  localparam int VCRC_ARB_WRR128   = 3;
  localparam int VCRC_ARB_TWRR128  = 4;
  localparam int VCRC_ARB_WRR256   = 5;

  typedef struct packed {
    logic [7:0] arbitration_table_location;
    logic       rsvd23;
    logic [6:0] slot_count;
    logic       snoop_reject;
    logic       switching_only_traffic;
    logic [5:0] rsvd13_8;
    logic [7:0] arbitration_scheme_support;
  } vcrc_cap_t;

  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic [VCRC_ADDR_W-1:0] addr;
    logic [3:0]             byte_en;
    logic [VCRC_DATA_W-1:0] wdata;
  } vcrc_req_t;

  typedef struct packed {
    logic                   ack;
    logic                   hit;
    logic [VCRC_DATA_W-1:0] rdata;
  } vcrc_rsp_t;

endpackage

// *** hw/vcrc_cap_word.sv ***
`timescale 1ns/1ps
module vcrc_cap_word
  import vcrc_pkg::*;
(
  output vcrc_cap_t cap
);

  logic [7:0] arb_bits;

  // Reserved scheme positions are forced low even if the mask says otherwise.
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_arb
      assign arb_bits[i] = VCRC_ARB_SUPPORT[i] & ~VCRC_ARB_RSVD[i]; // R8
    end
  endgenerate

  assign cap.arbitration_table_location = VCRC_TBL_LOC;     // R2
  assign cap.rsvd23                     = 1'h0;             // R3
  assign cap.slot_count                 = VCRC_SLOT_COUNT;  // R4
  assign cap.snoop_reject               = VCRC_SNOOP_REJ;   // R5
  assign cap.switching_only_traffic     = VCRC_SWITCH_ONLY; // R6
  assign cap.rsvd13_8                   = 6'h00;            // R7
  assign cap.arbitration_scheme_support = arb_bits;         // R9

endmodule

// *** tb/vcrc_host_model.sv ***
`timescale 1ns/1ps
module vcrc_host_model
  import vcrc_pkg::*;
(
  input  wire logic clk,
  output vcrc_req_t cfg_req
);
  initial cfg_req = '0;

  // Callers enter just after a rising edge; the strobe holds one full cycle.
  task automatic issue(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] be);
    begin
      cfg_req = '{1'b1, wr, a, be, d};
      @(posedge clk);
      #1;
    end
  endtask

  // Released fields are inverted so a stale request cannot pass for a held one.
  task automatic idle();
    begin
      cfg_req = '{1'b0, ~cfg_req.write, ~cfg_req.addr, ~cfg_req.byte_en,
                  ~cfg_req.wdata};
      @(posedge clk);
      #1;
    end
  endtask
endmodule

// *** tb/tb_vcrc_cap_reg.sv ***
`timescale 1ns/1ps
module tb_vcrc_cap_reg;
  import vcrc_pkg::*;
  logic        clk;
  logic        rst;
  vcrc_req_t   cfg_req;
  vcrc_rsp_t   cfg_rsp;
  vcrc_rsp_t   exp_q;
  int          bad_count;
  int          samples_checked;
  logic [31:0] seed;
  int          cap_word;

  vcrc_cap_reg vcrc_cap_reg_inst (.clk(clk), .rst(rst), .cfg_req(cfg_req),
                                  .cfg_rsp(cfg_rsp));
  vcrc_host_model vcrc_host_model_inst (.clk(clk), .cfg_req(cfg_req));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    begin
      samples_checked++;
      if (seen !== want)
      begin
        bad_count++;
        $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask

  task automatic print_verdict();
    begin
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // Reference: fields 31:24, 23, 22:16, 15, 14, 13:8 are zero, 7:0 is 01h.
  always @(posedge clk or posedge rst)
  begin
    cap_word = (0 << 24) | (0 << 23) | (0 << 16) | (0 << 15) | (0 << 14) | 1;
    if (rst)
      exp_q = '0;
    else
    begin
      exp_q.ack   = cfg_req.valid;
      exp_q.hit   = cfg_req.valid && ((cfg_req.addr >> 2) == (352 >> 2));
      exp_q.rdata = (exp_q.hit && !cfg_req.write) ? cap_word : 0;
    end
  end

  always @(negedge clk)
  begin
    check(cfg_rsp.ack, exp_q.ack);
    check(cfg_rsp.hit, exp_q.hit);
    check(cfg_rsp.rdata, exp_q.rdata);
    check(cfg_rsp.rdata[31:24], exp_q.rdata[31:24]);
    check(cfg_rsp.rdata[23], exp_q.rdata[23]);
    check(cfg_rsp.rdata[22:16], exp_q.rdata[22:16]);
    check(cfg_rsp.rdata[15], exp_q.rdata[15]);
    check(cfg_rsp.rdata[14], exp_q.rdata[14]);
    check(cfg_rsp.rdata[13:8], exp_q.rdata[13:8]);
    check(cfg_rsp.rdata[7:0], exp_q.rdata[7:0]);
  end

  initial
  begin
    #50000;
    bad_count++;
    print_verdict();
  end

  initial
  begin
    rst = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    seed = 32'hC51BD768;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
      vcrc_host_model_inst.issue(1'b0, 12'h15C + 12'(i), 32'h0, 4'hF);
    vcrc_host_model_inst.idle();
    $display("test back_to_back_reads done");
    vcrc_host_model_inst.issue(1'b1, 12'h160, 32'hFFFFFFFF, 4'hF);
    vcrc_host_model_inst.issue(1'b0, 12'h160, 32'h0, 4'h0);
    vcrc_host_model_inst.idle();
    $display("test write_ignored done");
    repeat (300)
    begin
      seed = lfsr(seed);
      vcrc_host_model_inst.issue(seed[0],
        seed[1] ? {10'h058, seed[3:2]} : seed[13:2], seed, seed[7:4]);
      if (seed[8])
        vcrc_host_model_inst.idle();
    end
    vcrc_host_model_inst.idle();
    $display("test random_traffic done");
    // The first read is answered and checked; the reset cuts the second.
    vcrc_host_model_inst.issue(1'b0, 12'h160, 32'h0, 4'hF);
    vcrc_host_model_inst.issue(1'b0, 12'h160, 32'h0, 4'hF);
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    vcrc_host_model_inst.issue(1'b0, 12'h160, 32'h0, 4'hF);
    vcrc_host_model_inst.idle();
    vcrc_host_model_inst.idle();
    $display("test midrun_reset done");
    print_verdict();
  end
endmodule
